// File: rtl/wpc_addr_cmp.sv
// wpc_addr_cmp: masked address compare of one comparator
// assumes mask already saturated to at most 24
`timescale 1ns/1ps
module wpc_addr_cmp
    import wpc_pkg::*;
(
    input wire logic [31:0] ref_val,
    input wire logic [MASK_W-1:0] mask,
    input wire logic fetch_mode,
    input wire logic [31:0] addr,
    output logic hit
);
    logic [31:0] care;
    always_comb begin
        care = 32'hffff_ffff << mask; // R4
        if (mask == '0 && fetch_mode) begin
            care[0] = 1'b0; // R3
        end
        hit = ((addr ^ ref_val) & care) == 32'h0000_0000;
    end
endmodule // wpc_addr_cmp

// File: rtl/wpc_data_cmp.sv
// wpc_data_cmp: data value compare of comparator zero
// assumes software replicated the value over all lanes of the reference
`timescale 1ns/1ps
module wpc_data_cmp
    import wpc_pkg::*;
(
    input wire logic [31:0] ref_val,
    input wire logic [1:0] size,
    input wire logic [31:0] data,
    input wire logic [1:0] acc_size,
    input wire logic [1:0] lane,
    output logic hit
);
    logic [31:0] diff;
    always_comb begin
        // lanes come from the replicated reference, so compare in place
        diff = data ^ ref_val; // R2
        hit = 1'b0;
        if (acc_size == size) begin
            unique case (size)
                SIZE_BYTE: hit = diff[8*lane +: 8] == 8'h00;
                SIZE_HALF: hit = diff[16*lane[1] +: 16] == 16'h0000;
                SIZE_WORD: hit = diff == 32'h0000_0000;
                default: hit = 1'b0;
            endcase
        end
    end
endmodule // wpc_data_cmp

// File: rtl/wpc_pkg.sv
// wpc_pkg: register map, field positions and encodings of the watchpoint comparators
// assumes word-indexed register port (index = byte offset / 4)
package wpc_pkg;
    localparam int unsigned ADDR_W = 6;
    // byte offsets relative to the unit base
    localparam logic [11:0] OFS_REF0 = 12'h020;
    localparam logic [11:0] OFS_MASK0 = 12'h024;
    localparam logic [11:0] OFS_FCT0 = 12'h028;
    localparam logic [11:0] OFS_REF1 = 12'h030;
    localparam logic [11:0] OFS_MASK1 = 12'h034;
    localparam logic [11:0] OFS_FCT1 = 12'h038;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h040;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h044;
    localparam logic [ADDR_W-1:0] IDX_REF0 = OFS_REF0[ADDR_W+1:2];
    localparam logic [ADDR_W-1:0] IDX_MASK0 = OFS_MASK0[ADDR_W+1:2];
    localparam logic [ADDR_W-1:0] IDX_FCT0 = OFS_FCT0[ADDR_W+1:2];
    localparam logic [ADDR_W-1:0] IDX_REF1 = OFS_REF1[ADDR_W+1:2];
    localparam logic [ADDR_W-1:0] IDX_MASK1 = OFS_MASK1[ADDR_W+1:2];
    localparam logic [ADDR_W-1:0] IDX_FCT1 = OFS_FCT1[ADDR_W+1:2];
    localparam logic [ADDR_W-1:0] IDX_IRQ_STAT = OFS_IRQ_STAT[ADDR_W+1:2];
    localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = OFS_IRQ_MASK[ADDR_W+1:2];
    // field layout
    localparam int unsigned MASK_W = 5;
    localparam logic [4:0] MASK_MAX = 5'h18;
    localparam int unsigned FCT_MATCHED_BIT = 24;
    localparam int unsigned FCT_DVADDR_BIT = 12;
    localparam int unsigned FCT_DVSIZE_LO = 10;
    localparam int unsigned FCT_DVMATCH_BIT = 8;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    typedef enum logic [3:0] {
        WPC_FN_OFF = 4'b0000,
        WPC_FN_FETCH = 4'b0100,
        WPC_FN_READ = 4'b0101,
        WPC_FN_WRITE = 4'b0110,
        WPC_FN_RDWR = 4'b0111
    } wpc_fn_e;
endpackage

// File: rtl/wpc_top.sv
// wpc_top: two watchpoint comparators with register port and match interrupt
// assumes bus access inputs are synchronous, one-cycle valid when access completes
// How it works
// R1: each comparator's reference register holds the 32-bit compare value
// R2: software replicates byte or halfword data values over all lanes
// R3: zero mask compares all address bits, bit 0 ignored for fetches
// R4: nonzero mask x ignores the low x address bits
// R5: mask writes above 24 are stored as 24
// R6: software keeps comparator zero mask zero during data value compares
// R7: reserved mask and function bits read zero, writes ignored
// R8: match flag sets on a match and clears on a read of its function register
// R9: function codes select off, fetch, read, write or read-write
// R10: comparator zero does address or data, comparator one address only
// R11: flag set in the access cycle; a match beats a clearing read
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module wpc_top
    import wpc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic acc_valid,
    input wire logic acc_fetch,
    input wire logic acc_write,
    input wire logic [31:0] acc_addr,
    input wire logic [31:0] acc_data,
    input wire logic [1:0] acc_size,
    output logic irq
);
    logic rst_meta_r;
    logic rst_sync_r;
    logic rst_n;
    logic [31:0] ref0_r;
    logic [31:0] ref1_r;
    logic [MASK_W-1:0] mask0_r;
    logic [MASK_W-1:0] mask1_r;
    logic [3:0] fn0_r;
    logic [3:0] fn1_r;
    logic dvmatch_r;
    logic dvaddr_r;
    logic [1:0] dvsize_r;
    logic matched0_r;
    logic matched1_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic addr_hit0;
    logic addr_hit1;
    logic data_hit0;
    logic act_ok0;
    logic act_ok1;
    logic match0;
    logic match1;
    logic rd_fct0;
    logic rd_fct1;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    assign rst_n = rst_sync_r;

    function automatic logic action_ok(input logic [3:0] fn, input logic fetch,
                                       input logic wr);
        unique case (fn)
            WPC_FN_FETCH: action_ok = fetch; // R9
            WPC_FN_READ: action_ok = !fetch && !wr;
            WPC_FN_WRITE: action_ok = !fetch && wr;
            WPC_FN_RDWR: action_ok = !fetch;
            default: action_ok = 1'b0;
        endcase
    endfunction

    function automatic logic [MASK_W-1:0] sat_mask(input logic [31:0] wd);
        // only the field bits count; upper bits are reserved
        if (wd[MASK_W-1:0] > MASK_MAX) begin
            sat_mask = MASK_MAX; // R5
        end else begin
            sat_mask = wd[MASK_W-1:0];
        end
    endfunction

    wpc_addr_cmp u_cmp0 (
        .ref_val(ref0_r),
        .mask(mask0_r),
        .fetch_mode(fn0_r == WPC_FN_FETCH),
        .addr(acc_addr),
        .hit(addr_hit0)
    );
    wpc_addr_cmp u_cmp1 (
        .ref_val(ref1_r),
        .mask(mask1_r),
        .fetch_mode(fn1_r == WPC_FN_FETCH),
        .addr(acc_addr),
        .hit(addr_hit1)
    );
    wpc_data_cmp u_dcmp0 (
        .ref_val(ref0_r),
        .size(dvsize_r),
        .data(acc_data),
        .acc_size(acc_size),
        .lane(acc_addr[1:0]),
        .hit(data_hit0)
    );

    assign act_ok0 = action_ok(fn0_r, acc_fetch, acc_write);
    assign act_ok1 = action_ok(fn1_r, acc_fetch, acc_write);
    // data value compare only on comparator zero, fetches never carry data
    assign match0 = acc_valid && act_ok0 && !(dvmatch_r && acc_fetch)
                    && (dvmatch_r ? data_hit0 : addr_hit0); // R10
    assign match1 = acc_valid && act_ok1 && addr_hit1; // R10
    assign rd_fct0 = reg_rd && reg_addr == IDX_FCT0;
    assign rd_fct1 = reg_rd && reg_addr == IDX_FCT1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref0_r <= REG_RESET;
            ref1_r <= REG_RESET;
            mask0_r <= '0;
            mask1_r <= '0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                IDX_REF0: ref0_r <= reg_wdata; // R1
                IDX_REF1: ref1_r <= reg_wdata; // R1
                IDX_MASK0: mask0_r <= sat_mask(reg_wdata); // R5
                IDX_MASK1: mask1_r <= sat_mask(reg_wdata); // R5
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fn0_r <= WPC_FN_OFF;
            fn1_r <= WPC_FN_OFF;
            dvmatch_r <= 1'b0;
            dvaddr_r <= 1'b0;
            dvsize_r <= SIZE_BYTE;
        end else if (reg_wr) begin
            if (reg_addr == IDX_FCT0) begin
                fn0_r <= reg_wdata[3:0]; // R9
                dvmatch_r <= reg_wdata[FCT_DVMATCH_BIT];
                dvsize_r <= reg_wdata[FCT_DVSIZE_LO +: 2];
                dvaddr_r <= reg_wdata[FCT_DVADDR_BIT];
            end
            if (reg_addr == IDX_FCT1) begin
                fn1_r <= reg_wdata[3:0]; // R10
            end
        end
    end

    // set wins over the read-clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            matched0_r <= 1'b0;
            matched1_r <= 1'b0;
        end else begin
            matched0_r <= match0 || (matched0_r && !rd_fct0); // R8 R11
            matched1_r <= match1 || (matched1_r && !rd_fct1); // R8 R11
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_r <= 2'h0;
            irq_mask_r <= 2'h0;
        end else begin
            if (reg_wr && reg_addr == IDX_IRQ_MASK) begin
                irq_mask_r <= reg_wdata[1:0];
            end
            if (reg_wr && reg_addr == IDX_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~reg_wdata[1:0]) | {match1, match0};
            end else begin
                irq_stat_r <= irq_stat_r | {match1, match0};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_nxt() & irq_mask_nxt());
        end
    end

    // irq follows next-state so it lines up with the status bits
    function automatic logic [1:0] irq_stat_nxt();
        if (reg_wr && reg_addr == IDX_IRQ_STAT) begin
            irq_stat_nxt = (irq_stat_r & ~reg_wdata[1:0]) | {match1, match0};
        end else begin
            irq_stat_nxt = irq_stat_r | {match1, match0};
        end
    endfunction

    function automatic logic [1:0] irq_mask_nxt();
        irq_mask_nxt = (reg_wr && reg_addr == IDX_IRQ_MASK) ? reg_wdata[1:0] : irq_mask_r;
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                IDX_REF0: reg_rdata <= ref0_r;
                IDX_REF1: reg_rdata <= ref1_r;
                IDX_MASK0: reg_rdata <= {27'h0, mask0_r}; // R7
                IDX_MASK1: reg_rdata <= {27'h0, mask1_r}; // R7
                IDX_FCT0: reg_rdata <= {7'h00, matched0_r, 11'h000, dvaddr_r, dvsize_r,
                                        1'b0, dvmatch_r, 4'h0, fn0_r}; // R7
                IDX_FCT1: reg_rdata <= {7'h00, matched1_r, 20'h00000, fn1_r};
                IDX_IRQ_STAT: reg_rdata <= {30'h0, irq_stat_r};
                IDX_IRQ_MASK: reg_rdata <= {30'h0, irq_mask_r};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    property p_match_sets;
        @(posedge clk) disable iff (!rst_n) match0 |=> matched0_r;
    endproperty
    a_match_sets: assert property (p_match_sets) else $error("match flag not set"); // R11

    property p_read_clears;
        @(posedge clk) disable iff (!rst_n) rd_fct0 && !match0 |=> !matched0_r;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear"); // R8

    property p_flag_holds;
        @(posedge clk) disable iff (!rst_n) matched1_r && !rd_fct1 |=> matched1_r;
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("flag lost"); // R8

    property p_mask_sat;
        @(posedge clk) disable iff (!rst_n) 1'b1 |-> mask0_r <= MASK_MAX && mask1_r <= MASK_MAX;
    endproperty
    a_mask_sat: assert property (p_mask_sat) else $error("mask above 24"); // R5

    property p_mask_wr;
        @(posedge clk) disable iff (!rst_n)
            reg_wr && reg_addr == IDX_MASK0 && reg_wdata[4:0] > MASK_MAX |=> mask0_r == MASK_MAX;
    endproperty
    a_mask_wr: assert property (p_mask_wr) else $error("mask not saturated"); // R5

    property p_off_no_match;
        @(posedge clk) disable iff (!rst_n) fn1_r == WPC_FN_OFF |-> !match1;
    endproperty
    a_off_no_match: assert property (p_off_no_match) else $error("disabled comparator hit"); // R9

    property p_mask_rd;
        @(posedge clk) disable iff (!rst_n) reg_rd && reg_addr == IDX_MASK1 |=> reg_rdata[31:5] == 0;
    endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("reserved mask bits set"); // R7

    // write then read-back of comparator one's reference, strobes back to back
    sequence s_ref1_write;
        reg_wr && reg_addr == IDX_REF1;
    endsequence

    sequence s_ref1_read;
        reg_rd && !reg_wr && reg_addr == IDX_REF1;
    endsequence

    property p_ref_wr;
        @(posedge clk) disable iff (!rst_n)
            s_ref1_write ##1 s_ref1_read |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_ref_wr: assert property (p_ref_wr) else $error("reference readback wrong"); // R1

    property p_fetch_bit0;
        @(posedge clk) disable iff (!rst_n)
            acc_valid && acc_fetch && fn1_r == WPC_FN_FETCH && mask1_r == 0
            && acc_addr[31:1] == ref1_r[31:1] |-> match1;
    endproperty
    a_fetch_bit0: assert property (p_fetch_bit0) else $error("fetch bit0 not ignored"); // R3

    property p_fct0_rsvd;
        @(posedge clk) disable iff (!rst_n)
            rd_fct0 |=> reg_rdata[31:25] == 7'h00 && reg_rdata[23:13] == 11'h000
            && !reg_rdata[9] && reg_rdata[7:4] == 4'h0;
    endproperty
    a_fct0_rsvd: assert property (p_fct0_rsvd) else $error("reserved function bits set"); // R7

    property p_fct1_rsvd;
        @(posedge clk) disable iff (!rst_n)
            rd_fct1 |=> reg_rdata[31:25] == 7'h00 && reg_rdata[23:4] == 20'h00000;
    endproperty
    a_fct1_rsvd: assert property (p_fct1_rsvd) else $error("data fields on comparator one"); // R10

    property p_flag_read;
        @(posedge clk) disable iff (!rst_n)
            rd_fct1 |=> reg_rdata[FCT_MATCHED_BIT] == $past(matched1_r);
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag not reported"); // R8

    property p_stat_set;
        @(posedge clk) disable iff (!rst_n) match1 |=> irq_stat_r[1];
    endproperty
    a_stat_set: assert property (p_stat_set) else $error("status not set"); // R11
endmodule // wpc_top

// File: verification/tb_wpc_top.sv
// tb_wpc_top: self-checking bench of the watchpoint comparators
// assumes wpc_bus_model supplies the watched access stream
`timescale 1ns/1ps
module tb_wpc_top
    import wpc_pkg::*;
;
    logic clk, reset_n, reg_wr, reg_rd, irq, acc_valid, acc_fetch, acc_write;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, acc_addr, acc_data, r;
    logic [1:0] acc_size, sz;
    int miscompares = 0, n_checks = 0;
    logic [31:0] m_ref[2] = '{default: '0}, m_fct[2] = '{default: '0};
    logic [4:0] m_mask[2] = '{default: '0};
    logic m_flag[2] = '{default: 1'b0};
    logic [1:0] m_stat = 2'h0, m_irqm = 2'h0;
    logic [ADDR_W-1:0] regs[9] = '{IDX_REF0, IDX_MASK0, IDX_FCT0, IDX_REF1, IDX_MASK1,
        IDX_FCT1, IDX_IRQ_STAT, IDX_IRQ_MASK, 6'h3f};
    logic [31:0] mv[7] = '{32'h0, 32'h1, 32'h17, 32'h18, 32'h19, 32'h25, 32'hffff_ffe3};
    wpc_fn_e fns[5] = '{WPC_FN_OFF, WPC_FN_FETCH, WPC_FN_READ, WPC_FN_WRITE, WPC_FN_RDWR};

    wpc_top dut_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_valid(acc_valid),
        .acc_fetch(acc_fetch), .acc_write(acc_write), .acc_addr(acc_addr),
        .acc_data(acc_data), .acc_size(acc_size), .irq(irq));
    wpc_bus_model bus_u (.clk(clk), .acc_valid(acc_valid), .acc_fetch(acc_fetch),
        .acc_write(acc_write), .acc_addr(acc_addr), .acc_data(acc_data), .acc_size(acc_size));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    function automatic bit m_hit(int c, bit f, bit w, logic [31:0] a, logic [31:0] d,
                                 logic [1:0] s);
        logic [31:0] care;
        int fn;
        fn = int'(m_fct[c][3:0]);
        if (!((fn == 4 && f) || (!f && (fn == 7 || (fn == 5 && !w) || (fn == 6 && w)))))
            return 1'b0;
        if (c == 0 && m_fct[0][FCT_DVMATCH_BIT])
            return s == m_fct[0][11:10] && d == m_ref[0];
        care = (m_mask[c] == 0) ? ((fn == 4) ? 32'hffff_fffe : 32'hffff_ffff)
                                : (32'hffff_ffff << m_mask[c]);
        return ((a ^ m_ref[c]) & care) == 32'h0;
    endfunction

    task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        case (a)
            IDX_REF0, IDX_REF1: m_ref[a == IDX_REF1] = d;
            IDX_MASK0, IDX_MASK1: m_mask[a == IDX_MASK1] = (d[4:0] > 5'h18) ? 5'h18 : d[4:0];
            IDX_FCT0: m_fct[0] = d & 32'h0000_1d0f;
            IDX_FCT1: m_fct[1] = d & 32'h0000_000f;
            IDX_IRQ_STAT: m_stat &= ~d[1:0];
            IDX_IRQ_MASK: m_irqm = d[1:0];
            default: ;
        endcase
    endtask

    task automatic rdchk(logic [ADDR_W-1:0] a, bit ign = 1'b0);
        logic [31:0] e;
        e = 32'h0;
        case (a)
            IDX_REF0, IDX_REF1: e = m_ref[a == IDX_REF1];
            IDX_MASK0, IDX_MASK1: e = 32'(m_mask[a == IDX_MASK1]);
            IDX_FCT0, IDX_FCT1: begin
                e = m_fct[a == IDX_FCT1] | (32'(m_flag[a == IDX_FCT1]) << FCT_MATCHED_BIT);
                m_flag[a == IDX_FCT1] = 1'b0;
            end
            IDX_IRQ_STAT: e = 32'(m_stat);
            IDX_IRQ_MASK: e = 32'(m_irqm);
            default: ;
        endcase
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        if (!ign)
            chk(reg_rdata, e);
    endtask

    // write then read back with no idle cycle between the two strobes
    task automatic wr_rd(logic [ADDR_W-1:0] a, logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        m_ref[a == IDX_REF1] = d;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, d);
    endtask

    // model is updated after the access edge so a read started alongside clears first
    task automatic acc(bit f, bit w, logic [31:0] a, logic [31:0] d, logic [1:0] s);
        bus_u.access(f, w, a, d, s);
        for (int c = 0; c < 2; c++) begin
            if (m_hit(c, f, w, a, d, s)) begin
                m_flag[c] = 1'b1;
                m_stat[c] = 1'b1;
            end
        end
        @(posedge clk);
        #1;
        chk(32'(irq), 32'(|(m_stat & m_irqm)));
    endtask

    initial begin
        #1_000_000;
        miscompares++;
        report_and_stop();
    end

    initial begin
        reset_n = 1'b0;
        reg_addr = '0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        void'($urandom(27));
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (regs[i])
            rdchk(regs[i]);
        $display("test reset done");
        foreach (regs[i]) begin
            wr(regs[i], 32'hffff_ffff);
            rdchk(regs[i]);
        end
        foreach (mv[i]) begin
            wr(IDX_MASK0, mv[i]);
            rdchk(IDX_MASK0);
        end
        $display("test registers done");
        wr(IDX_MASK0, 32'h0);
        wr(IDX_FCT1, 32'h0);
        foreach (fns[i]) begin
            for (int k = 0; k < 3; k++) begin
                r = $urandom;
                wr(IDX_REF0, r);
                wr(IDX_FCT0, 32'(fns[i]));
                acc(k == 0, k == 2, r & 32'hffff_fffe, $urandom, SIZE_WORD);
                rdchk(IDX_FCT0);
                rdchk(IDX_IRQ_STAT);
                wr(IDX_IRQ_STAT, 32'h3);
            end
        end
        $display("test functions done");
        wr(IDX_FCT0, 32'h0);
        for (int md = 0; md < 2; md++) begin
            foreach (mv[i]) begin
                r = $urandom;
                wr(IDX_REF1, r);
                wr(IDX_MASK1, mv[i]);
                wr(IDX_FCT1, md ? 32'(WPC_FN_FETCH) : 32'(WPC_FN_READ));
                for (int k = 0; k < 32; k++) begin
                    acc(md, 1'b0, r ^ (32'h1 << k), 32'h0, SIZE_WORD);
                    rdchk(IDX_FCT1);
                end
            end
        end
        $display("test masks done");
        wr(IDX_FCT1, 32'h0);
        wr(IDX_MASK0, 32'h0);
        for (int k = 0; k < 5; k++) begin
            r = {4{8'($urandom)}};
            sz = (k < 3) ? 2'(k) : SIZE_WORD;
            wr(IDX_REF0, r);
            wr(IDX_FCT0, 32'(WPC_FN_RDWR) | 32'h100 | (32'(sz) << FCT_DVSIZE_LO));
            acc(1'b0, k[0], $urandom & 32'hffff_fffc, (k == 3) ? r ^ 32'h1 : r,
                (k == 4) ? SIZE_BYTE : sz);
            rdchk(IDX_FCT0);
        end
        $display("test data values done");
        r = $urandom;
        wr(IDX_FCT0, 32'(WPC_FN_WRITE));
        wr(IDX_REF0, r);
        wr(IDX_IRQ_MASK, 32'h0);
        acc(1'b0, 1'b1, r, 32'h0, SIZE_WORD);
        rdchk(IDX_IRQ_STAT);
        fork
            rdchk(IDX_FCT0, 1'b1);
            acc(1'b0, 1'b1, r, 32'h0, SIZE_WORD);
        join
        rdchk(IDX_FCT0);
        rdchk(IDX_FCT0);
        $display("test read clear race done");
        wr_rd(IDX_REF1, $urandom);
        wr_rd(IDX_REF0, $urandom);
        $display("test write read back done");
        report_and_stop();
    end
endmodule // tb_wpc_top

// File: verification/wpc_bus_model.sv
// wpc_bus_model: processor bus access stream watched by the comparators
// assumes callers start an access just after a rising clock edge
`timescale 1ns/1ps
module wpc_bus_model (
    input wire logic clk,
    output logic acc_valid,
    output logic acc_fetch,
    output logic acc_write,
    output logic [31:0] acc_addr,
    output logic [31:0] acc_data,
    output logic [1:0] acc_size
);
    initial begin
        acc_valid = 1'b0;
        acc_fetch = 1'b0;
        acc_write = 1'b0;
        acc_addr = 32'h0;
        acc_data = 32'h0;
        acc_size = 2'h0;
    end

    // one completing access; idle lines are inverted so stale values never fake a hit
    task automatic access(bit f, bit w, logic [31:0] a, logic [31:0] d, logic [1:0] s);
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_fetch <= f;
        acc_write <= w;
        acc_addr <= a;
        acc_data <= d;
        acc_size <= s;
        @(posedge clk);
        acc_valid <= 1'b0;
        acc_fetch <= ~f;
        acc_write <= ~w;
        acc_addr <= ~a;
        acc_data <= ~d;
        acc_size <= ~s;
    endtask
endmodule // wpc_bus_model
